// ==== rtl/sdrg_map.vh ====
// constants for the delta-sigma rate generator
// assumes inclusion by the rate generator design files only
`ifndef SDRG_MAP_VH
`define SDRG_MAP_VH

// ****************************************************************
// timing
// ****************************************************************
`define SDRG_MOD_DIV        6
`define SDRG_OSR            64
`define SDRG_ORDER          5
`define SDRG_VALID_PULSE    6
`define SDRG_ACC_W          32
`define SDRG_RES_W          24
`define SDRG_LOW_CYCLES     8
`define SDRG_ZERO32         32'h0000_0000

`endif

// ==== rtl/sdrg_sinc_stage.v ====
// one integrator and one comb of the sinc decimator
// assumes a sample strobe and a decimation strobe from the rate counter
`timescale 1ns/1ps
`default_nettype none

module sdrg_sinc_stage #(
    parameter W = 32
) (
    input  wire         ref_clk,
    input  wire         arst_n,
    input  wire         smp_stb,
    input  wire         dec_stb,
    input  wire [W-1:0] int_in,
    input  wire [W-1:0] comb_in,
    output reg  [W-1:0] int_q,
    output reg  [W-1:0] comb_q
);

    reg [W-1:0] dly_q;

    // comb is combinational so the chain adds no decimated-rate latency
    always @* begin
        comb_q = comb_in - dly_q;
    end

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            int_q <= {W{1'b0}};
            dly_q <= {W{1'b0}};
        end else begin
            if (smp_stb) begin
                int_q <= int_q + int_in;
            end
            if (dec_stb) begin
                dly_q <= comb_in;
            end
        end
    end

endmodule

`default_nettype wire

// ==== rtl/sdrg_rate_gen.v ====
// conversion timing and result delivery of a delta-sigma converter
// assumes mod_bit is the modulator output, sampled on each modulator tick
//
// Behaviour
// - the modulator clock is the system clock divided by a fixed six.
// - each result spans a fixed 64 modulator samples.
// - at 16 MHz the modulator runs near 2.667 MHz and results near 41.667 kHz.
// - the result rate scales directly with the system clock.
// - all sampling and conversion timing runs on the system clock.
// - a fifth-order sinc decimator filters the bitstream into the output register.
// - after each new result the data-out/ready line is driven low.
// - the filter needs five conversions to settle after an input step.
// - ready pulses from the first conversion, only the sixth onward is valid.
`timescale 1ns/1ps
`default_nettype none
`include "sdrg_map.vh"

module sdrg_rate_gen #(
    parameter MOD_DIV    = `SDRG_MOD_DIV,
    parameter OSR        = `SDRG_OSR,
    parameter LOW_CYCLES = `SDRG_LOW_CYCLES
) (
    input  wire                    ref_clk,
    input  wire                    arst_n,
    input  wire                    mod_bit,
    output reg                     mod_clk_q,
    output reg                     data_out_ready_line_q,
    output reg                     result_valid_q,
    output reg  [`SDRG_RES_W-1:0]  result_q
);

    localparam AW = `SDRG_ACC_W;

    // ****************************************************************
    // prescaler and decimation counters
    // ****************************************************************
    reg [7:0] pre_q;
    reg [7:0] dec_q;
    reg [3:0] conv_q;
    reg [7:0] low_q;
    wire smp_stb = (pre_q == MOD_DIV - 1);
    wire dec_stb = smp_stb && (dec_q == OSR - 1);

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pre_q     <= 8'h00;
            dec_q     <= 8'h00;
            mod_clk_q <= 1'b0;
        end else begin
            pre_q     <= smp_stb ? 8'h00 : pre_q + 8'h01;
            mod_clk_q <= (pre_q < MOD_DIV / 2);
            if (smp_stb) begin
                dec_q <= (dec_q == OSR - 1) ? 8'h00 : dec_q + 8'h01;
            end
        end
    end

    // ****************************************************************
    // fifth-order sinc decimator
    // ****************************************************************
    wire [AW-1:0] int_o  [0:`SDRG_ORDER-1];
    wire [AW-1:0] comb_o [0:`SDRG_ORDER-1];
    wire [AW-1:0] in_bit = {{(AW-1){1'b0}}, mod_bit};

    genvar g;
    generate
        for (g = 0; g < `SDRG_ORDER; g = g + 1) begin : stg
            wire [AW-1:0] int_src;
            wire [AW-1:0] comb_src;
            // first stage takes the bitstream and the last integrator
            if (g == 0) begin : head
                assign int_src  = in_bit;
                assign comb_src = int_o[`SDRG_ORDER-1];
            end else begin : tail
                assign int_src  = int_o[g-1];
                assign comb_src = comb_o[g-1];
            end
            sdrg_sinc_stage #(
                .W (AW)
            ) u_stage (
                .ref_clk (ref_clk),
                .arst_n  (arst_n),
                .smp_stb (smp_stb),
                .dec_stb (dec_stb),
                .int_in  (int_src),
                .comb_in (comb_src),
                .int_q   (int_o[g]),
                .comb_q  (comb_o[g])
            );
        end
    endgenerate

    // ****************************************************************
    // output register, ready line and settling count
    // ****************************************************************
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            result_q              <= {`SDRG_RES_W{1'b0}};
            data_out_ready_line_q <= 1'b1;
            result_valid_q        <= 1'b0;
            conv_q                <= 4'h0;
            low_q                 <= 8'h00;
        end else begin
            if (dec_stb) begin
                // gain is 64^5 = 2^30, keep the top 24 of 31 bits
                result_q <= comb_o[`SDRG_ORDER-1][AW-2:AW-1-`SDRG_RES_W];
                data_out_ready_line_q <= 1'b0;
                low_q <= LOW_CYCLES[7:0];
                if (conv_q != `SDRG_VALID_PULSE) begin
                    conv_q <= conv_q + 4'h1;
                end
                result_valid_q <= (conv_q + 4'h1 >= `SDRG_VALID_PULSE);
            end else if (low_q != 8'h00) begin
                low_q <= low_q - 8'h01;
                data_out_ready_line_q <= (low_q == 8'h01);
            end
        end
    end

endmodule

`default_nettype wire

// ==== tb/sdrg_chk_sva.sv ====
// timing checker for the rate generator
// assumes binding onto sdrg_rate_gen ports
`timescale 1ns/1ps
`default_nettype none
module sdrg_chk #(parameter MOD_DIV=6, OSR=64, LOW_CYCLES=8) (
    input wire logic        ref_clk, arst_n, mod_bit, mod_clk_q,
    input wire logic        data_out_ready_line_q, result_valid_q,
    input wire logic [23:0] result_q);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    wire r = data_out_ready_line_q;
    property p_div; $rose(mod_clk_q) |=> mod_clk_q[*2] ##1 !mod_clk_q[*3]
        ##1 mod_clk_q; endproperty
    a_div: assert property (p_div) else $error("mod clk shape");
    property p_low; $fell(r) |-> !r[*8] ##1 r; endproperty
    a_low: assert property (p_low) else $error("ready low width");
    property p_per; $fell(r) |-> ##[384:384] $fell(r); endproperty
    a_per: assert property (p_per) else $error("period");
    property p_high; $rose(r) |-> r[*8]; endproperty
    a_high: assert property (p_high) else $error("ready gap");
    property p_res; !$stable(result_q) |-> ##[0:1] !r; endproperty
    a_res: assert property (p_res) else $error("result load");
    property p_std; $fell(r) |=> ##1 $stable(result_q)[*8]; endproperty
    a_std: assert property (p_std) else $error("result hold");
    property p_vr; $rose(result_valid_q) |-> !r; endproperty
    a_vr: assert property (p_vr) else $error("valid rise");
    property p_vh; result_valid_q |=> result_valid_q; endproperty
    a_vh: assert property (p_vh) else $error("valid drop");
endmodule
bind sdrg_rate_gen sdrg_chk #(.MOD_DIV(MOD_DIV), .OSR(OSR),
    .LOW_CYCLES(LOW_CYCLES)) u_chk (.*);
`default_nettype wire

// ==== tb/sdrg_mcu.sv ====
// controller model reading the ready line
// assumes the ready line idles high
`timescale 1ns/1ps
`default_nettype none
module sdrg_mcu (
    input  wire logic ref_clk, arst_n, rdy,
    output wire logic ok);
    logic [2:0] cnt_q;
    logic       prev_q;
    assign ok = (cnt_q >= 3'h6);
    always @(posedge ref_clk or negedge arst_n)
        if (!arst_n) begin
            cnt_q <= 3'h0;
            prev_q <= 1'b1;
        end else begin
            prev_q <= rdy;
            if (prev_q && !rdy && cnt_q < 3'h6) cnt_q <= cnt_q + 3'h1;
        end
endmodule
`default_nettype wire

// ==== tb/sdrg_rate_gen_bench.sv ====
// self-checking bench of the rate generator
// assumes default parameters of the design
`timescale 1ns/1ps
`default_nettype none
module sdrg_rate_gen_bench;
    logic ref_clk = 0, arst_n = 0, mod_bit = 0, rdy, vld, ok;
    logic [23:0] res;
    logic [31:0] seed = 32'h3a23_5e92;
    int mismatches = 0, checks_done = 0, cyc = 0, n;
    sdrg_rate_gen DUT (.ref_clk(ref_clk), .arst_n(arst_n), .mod_bit(mod_bit),
        .mod_clk_q(), .data_out_ready_line_q(rdy), .result_valid_q(vld),
        .result_q(res));
    sdrg_mcu u_mcu (.ref_clk(ref_clk), .arst_n(arst_n), .rdy(rdy), .ok(ok));
    initial forever #2.5 ref_clk = ~ref_clk;
    task chk(input logic [23:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    function automatic logic [31:0] xorshift(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    // settled level: gain 64 to the fifth, top 24 of 31 bits
    function automatic logic [23:0] level(input logic b);
        longint g;
        g = 1;
        repeat (5) g = g * 64;
        return b ? 24'(g >> 7) : 24'h00_0000;
    endfunction
    // drive bits until ready has been high and falls, plus 4 cycles
    task fall(input int mode);
        logic seen_hi;
        n = 0;
        seen_hi = 1'b0;
        while (!(seen_hi && rdy === 1'b0)) begin
            if (rdy === 1'b1) seen_hi = 1'b1;
            @(posedge ref_clk);
            n++;
            seed = xorshift(seed);
            mod_bit <= (mode == 2) ? seed[0] : mode[0];
        end
        repeat (4) @(posedge ref_clk);
        n += 4;
    endtask
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            complete_run;
        end
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            fall(2);
            if (i > 0) chk(n, 384);
            chk(vld, ok);
        end
        $display("test rate done");
        for (int b = 1; b >= 0; b--) begin
            for (int i = 0; i < 7; i++) fall(b);
            chk(res, level(b[0]));
            $display("test step done");
        end
        complete_run;
    end
endmodule
`default_nettype wire
